// *** hw/tplp_defines.svh ***
// constants for the twisted pair link test and polarity block
// Summary of operation
// - no packet or link pulse for over 60 ms puts the port in link fail
// - link fail ends on a packet or six unbroken link pulses
// - in link fail the transmitter sends no packets and no link pulses
// - the first packet received in link fail is not repeated
// - in link good, link pulses go out after 16 ms of transmit idle
// - link test disabled holds the port in link good
// - link test is enabled by every reset
// - software enables or disables link test over the register bus
// - first packet sets polarity from its sign; three negative link pulses in a row mark polarity negative
// - a port marked negative repeats inverted data once in link good
// - a port not marked negative repeats data unchanged
// - polarity stays frozen until reset or a new link fail entry
// - auto polarity is enabled by reset and switchable by software
// - polarity status reads as correct while reset is held
// - reset puts every port in link fail, transmitter idle
`ifndef TPLP_DEFINES_SVH
`define TPLP_DEFINES_SVH
`define TPLP_CLK_HZ      20000000
`define TPLP_FAIL_MS     60
`define TPLP_LP_IDLE_MS  16
`define TPLP_RESET_US    100
`define TPLP_GOOD_RUN    6
`define TPLP_NEG_RUN     3
`define TPLP_IDLE_W      21
`define TPLP_TX_W        19
`define TPLP_RUN_W       3
`define TPLP_ADDR_W      5
`define TPLP_ADDR_CTRL   5'h00
`define TPLP_ADDR_LINK   5'h04
`define TPLP_ADDR_POL    5'h08
`define TPLP_ADDR_ISTAT  5'h0c
`define TPLP_ADDR_IMASK  5'h10
`define TPLP_CTRL_LT     0
`define TPLP_CTRL_AP     1
`define TPLP_CTRL_RST    2'h3
`endif

// *** hw/tplp_pkg.sv ***
// types for the twisted pair link test and polarity block
`include "tplp_defines.svh"
package tplp_pkg;
  typedef struct packed {
    logic crs;
    logic data;
    logic neg;
    logic lp;
    logic lp_neg;
  } tplp_rx_s;

  typedef struct packed {
    logic req;
    logic data;
  } tplp_txin_s;

  typedef struct packed {
    logic en;
    logic data;
    logic lp;
  } tplp_tx_s;

  typedef struct packed {
    logic vld;
    logic data;
  } tplp_rpt_s;

  typedef struct packed {
    logic                    link_good;
    logic [`TPLP_IDLE_W-1:0] idle_cnt;
    logic [`TPLP_TX_W-1:0]   tx_cnt;
    logic [`TPLP_RUN_W-1:0]  lp_run;
    logic [`TPLP_RUN_W-1:0]  neg_run;
    logic                    pol_known;
    logic                    pol_neg;
    logic                    crs_d;
    logic                    suppress;
    tplp_rpt_s               rpt;
    tplp_tx_s                tx;
  } tplp_port_s;
endpackage

// *** hw/tplp_top.sv ***
// per-port link integrity and auto polarity with avalon register slave
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "tplp_defines.svh"
module tplp_top #(
  parameter int NPORTS   = 8,
  parameter int FAIL_CYC = `TPLP_FAIL_MS * (`TPLP_CLK_HZ / 1000),
  parameter int TXI_CYC  = `TPLP_LP_IDLE_MS * (`TPLP_CLK_HZ / 1000)
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire tplp_pkg::tplp_rx_s      rx          [NPORTS],
  input  wire tplp_pkg::tplp_txin_s    tx_in       [NPORTS],
  output tplp_pkg::tplp_tx_s           tx_out      [NPORTS],
  output tplp_pkg::tplp_rpt_s          rpt         [NPORTS],
  output logic [NPORTS-1:0]            link_status,
  output logic [NPORTS-1:0]            pol_status,
  input  wire logic [`TPLP_ADDR_W-1:0] avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic [31:0]                  avs_readdata,
  output logic                         avs_waitrequest,
  output logic                         irq
);
  import tplp_pkg::*;

  localparam logic [`TPLP_IDLE_W-1:0] FAIL_C = FAIL_CYC[`TPLP_IDLE_W-1:0];
  localparam logic [`TPLP_TX_W-1:0]   TXI_C  = TXI_CYC[`TPLP_TX_W-1:0];
  localparam logic [`TPLP_RUN_W-1:0]  GOOD_C =
    `TPLP_RUN_W'(`TPLP_GOOD_RUN - 1);
  localparam logic [`TPLP_RUN_W-1:0]  NEG_C  =
    `TPLP_RUN_W'(`TPLP_NEG_RUN - 1);
  localparam int                      LT     = `TPLP_CTRL_LT;
  localparam int                      AP     = `TPLP_CTRL_AP;

  typedef struct packed {
    tplp_port_s [NPORTS-1:0] p;
    logic [1:0]              ctrl;
    logic [NPORTS-1:0]       istat;
    logic [NPORTS-1:0]       imask;
    logic                    ack;
    logic [31:0]             rdata;
  } tplp_state_s;

  tplp_state_s       s_reg;
  tplp_state_s       s_next;
  logic [NPORTS-1:0] pkt_start;
  logic [NPORTS-1:0] fail_entry;

  function automatic logic [`TPLP_RUN_W-1:0] run_inc(
    input logic [`TPLP_RUN_W-1:0] v,
    input logic [`TPLP_RUN_W-1:0] top
  );
    run_inc = (v == top) ? v : `TPLP_RUN_W'(v + 1'b1);
  endfunction

  function automatic logic [31:0] rd_word(
    input tplp_state_s              st,
    input logic [`TPLP_ADDR_W-1:0]  a
  );
    logic [NPORTS-1:0] lk;
    logic [NPORTS-1:0] pl;
    lk = '0;
    pl = '0;
    for (int k = 0; k < NPORTS; k++) begin
      lk[k] = st.p[k].link_good;
      pl[k] = st.p[k].pol_neg;
    end
    case (a)
      `TPLP_ADDR_CTRL:  rd_word = 32'(st.ctrl);
      `TPLP_ADDR_LINK:  rd_word = 32'(lk);
      `TPLP_ADDR_POL:   rd_word = 32'(pl);
      `TPLP_ADDR_ISTAT: rd_word = 32'(st.istat);
      `TPLP_ADDR_IMASK: rd_word = 32'(st.imask);
      default:          rd_word = 32'h0;
    endcase
  endfunction

  always_comb begin
    tplp_port_s        pi;
    tplp_port_s        q;
    logic [NPORTS-1:0] ev;
    logic [NPORTS-1:0] clr;
    logic              act;
    logic              tmo;
    logic              req;
    pi = '0;
    q = '0;
    ev = '0;
    clr = '0;
    act = 1'b0;
    tmo = 1'b0;
    s_next = s_reg;
    for (int i = 0; i < NPORTS; i++) begin
      pi = s_reg.p[i];
      q = pi;
      act = rx[i].crs | rx[i].lp;
      tmo = (pi.idle_cnt == FAIL_C);
      q.crs_d = rx[i].crs;
      // one idle timer and one transmit timer per port
      if (act) begin
        q.idle_cnt = '0;
      end else if (!tmo) begin
        q.idle_cnt = `TPLP_IDLE_W'(pi.idle_cnt + 1'b1);
      end
      // a silence that reaches the fail timeout (idle_cnt at FAIL_C) breaks the pulse run
      if (rx[i].lp) begin
        q.lp_run = run_inc(pi.lp_run, GOOD_C);
      end else if (tmo) begin
        q.lp_run = '0;
      end
      if (!s_reg.ctrl[LT]) begin
        q.link_good = 1'b1;
      end else if (pi.link_good && tmo) begin
        q.link_good = 1'b0;
      end else if (!pi.link_good &&
                   (pkt_start[i] || (rx[i].lp && pi.lp_run == GOOD_C))) begin
        q.link_good = 1'b1;
      end
      if (fail_entry[i]) begin
        q.pol_known = 1'b0;
        q.pol_neg = 1'b0;
        q.neg_run = '0;
        q.lp_run = '0;
      end else if (!pi.pol_known && s_reg.ctrl[AP]) begin
        if (pkt_start[i]) begin
          q.pol_known = 1'b1;
          q.pol_neg = rx[i].neg;
        end else if (rx[i].lp && rx[i].lp_neg) begin
          q.neg_run = run_inc(pi.neg_run, NEG_C);
          // run saturates at NEG_C, so the third pulse sees it there
          if (pi.neg_run == NEG_C) begin
            q.pol_known = 1'b1;
            q.pol_neg = 1'b1;
          end
        end else if (rx[i].lp) begin
          q.neg_run = '0;
        end
      end
      // packet that wakes a failed port is still dropped whole
      if (pkt_start[i]) begin
        q.suppress = !pi.link_good;
      end else if (!rx[i].crs) begin
        q.suppress = 1'b0;
      end
      q.rpt.vld = rx[i].crs && q.link_good && !q.suppress;
      q.rpt.data = rx[i].data ^ (q.pol_neg & q.link_good);
      q.tx.en = tx_in[i].req && q.link_good;
      q.tx.data = tx_in[i].data;
      q.tx.lp = 1'b0;
      if (tx_in[i].req || !q.link_good) begin
        q.tx_cnt = '0;
      end else if (pi.tx_cnt == TXI_C) begin
        q.tx_cnt = '0;
        q.tx.lp = 1'b1;
      end else begin
        q.tx_cnt = `TPLP_TX_W'(pi.tx_cnt + 1'b1);
      end
      ev[i] = q.link_good ^ pi.link_good;
      s_next.p[i] = q;
    end
    // register slave: one wait cycle, read data captured on the same edge as the ack
    req = avs_read | avs_write;
    s_next.ack = req & ~s_reg.ack;
    if (req && !s_reg.ack) begin
      s_next.rdata = rd_word(s_reg, avs_address);
    end
    if (s_reg.ack && avs_read && avs_address == `TPLP_ADDR_ISTAT) begin
      clr = s_reg.rdata[NPORTS-1:0];
    end
    // only bits actually returned are cleared; a new event wins
    s_next.istat = (s_reg.istat & ~clr) | ev;
    if (s_reg.ack && avs_write && avs_byteenable[0]) begin
      case (avs_address)
        `TPLP_ADDR_CTRL:  s_next.ctrl = avs_writedata[1:0];
        `TPLP_ADDR_IMASK: s_next.imask = avs_writedata[NPORTS-1:0];
        default:          s_next.ctrl = s_reg.ctrl;
      endcase
    end
    if (reset) begin
      s_next = '0;
      s_next.ctrl = `TPLP_CTRL_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    s_reg <= s_next;
  end

  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    assign pkt_start[g] = rx[g].crs & ~s_reg.p[g].crs_d;
    assign fail_entry[g] = s_reg.ctrl[LT] & s_reg.p[g].link_good &
                           (s_reg.p[g].idle_cnt == FAIL_C);
    assign tx_out[g] = s_reg.p[g].tx;
    assign rpt[g] = s_reg.p[g].rpt;
    assign link_status[g] = s_reg.p[g].link_good;
    // status forced correct while reset is held
    assign pol_status[g] = s_reg.p[g].pol_neg & ~reset;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.ack;
  assign avs_readdata = s_reg.rdata;
  assign irq = |(s_reg.istat & s_reg.imask);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  for (genvar a = 0; a < NPORTS; a++) begin : g_chk
    sequence seq_fail_start;
      $rose(rx[a].crs) && !s_reg.p[a].link_good && s_reg.ctrl[LT];
    endsequence

    sequence seq_pkt_body;
      rx[a].crs [*1];
    endsequence

    property p_first_drop;
      seq_fail_start ##0 seq_pkt_body |=> !s_reg.p[a].rpt.vld;
    endproperty

    a_fail_timeout: assert property (
      fail_entry[a] |=> !s_reg.p[a].link_good && !s_reg.p[a].tx.en)
      else $error("port did not fail after idle timeout");

    a_fail_hold: assert property (
      !s_reg.p[a].link_good && s_reg.ctrl[LT] && !rx[a].lp && !rx[a].crs
      |=> !s_reg.p[a].link_good)
      else $error("port left link fail without traffic");

    a_tx_quiet: assert property (
      !s_reg.p[a].link_good |-> !s_reg.p[a].tx.en && !s_reg.p[a].tx.lp)
      else $error("transmit activity in link fail");

    a_first_drop: assert property (p_first_drop)
      else $error("first packet in link fail was repeated");

    a_lp_idle: assert property (
      s_reg.p[a].link_good && s_reg.p[a].tx_cnt == TXI_C && !tx_in[a].req
      && !fail_entry[a] |=> s_reg.p[a].tx.lp ##1 !s_reg.p[a].tx.lp)
      else $error("link pulse missing after transmit idle");

    a_lt_off: assert property (
      !s_reg.ctrl[LT] |=> s_reg.p[a].link_good [*2])
      else $error("link test off but port not good");

    a_rpt_polarity: assert property (
      s_reg.p[a].rpt.vld |-> s_reg.p[a].rpt.data ==
      ($past(rx[a].data) ^ s_reg.p[a].pol_neg))
      else $error("repeated data polarity wrong");

    a_pol_frozen: assert property (
      s_reg.p[a].pol_known && !fail_entry[a]
      |=> $stable(s_reg.p[a].pol_neg) && s_reg.p[a].pol_known)
      else $error("frozen polarity changed");

    a_neg_lp: assert property (
      !s_reg.p[a].pol_known && s_reg.ctrl[AP] && !fail_entry[a] &&
      rx[a].lp && rx[a].lp_neg && s_reg.p[a].neg_run == 3'd2
      |=> s_reg.p[a].pol_neg && s_reg.p[a].pol_known)
      else $error("three negative pulses not marked");
  end

  a_ctrl_reset: assert property (
    $past(reset) |-> s_reg.ctrl == `TPLP_CTRL_RST &&
    link_status == '0 [*1])
    else $error("control not enabled after reset");

  a_bus_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
endmodule

// *** testbench/tplp_remote.sv ***
// remote station model for one twisted pair receive port
`timescale 1ns/1ps
module tplp_remote (
  input  wire tplp_pkg::tplp_tx_s tx,
  input  wire logic               sys_clk,
  output tplp_pkg::tplp_rx_s      rx
);
  import tplp_pkg::*;
  int   lp_cnt = 0;
  logic hold   = 1'b0;
  initial rx = '0;
  // idle line toggles so a stale bit never passes as data
  always @(posedge sys_clk) begin
    if (tx.lp) lp_cnt <= lp_cnt + 1;
    if (!hold) rx.data <= ~rx.data;
  end
  // one-cycle pulses, gaps far below the fail time
  task automatic pulses(input int k, input logic neg);
    repeat (k) begin
      @(posedge sys_clk);
      rx.lp     <= 1'b1;
      rx.lp_neg <= neg;
      @(posedge sys_clk);
      rx.lp     <= 1'b0;
      rx.lp_neg <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    #1;
  endtask
  task automatic packet(input int len, input logic neg,
                        input logic [31:0] bits);
    hold = 1'b1;
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      rx.crs  <= 1'b1;
      rx.neg  <= neg;
      rx.data <= bits[i];
    end
    @(posedge sys_clk);
    rx.crs <= 1'b0;
    hold = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the link test and polarity block
`timescale 1ns/1ps
module testbench;
  import tplp_pkg::*;
  localparam int FAIL = 200;
  localparam int TXI  = 50;
  logic        sys_clk, reset, irq, avs_read, avs_write;
  logic        avs_waitrequest, exp_vld, exp_inv, d_smp, v_smp;
  tplp_rx_s    rx     [2];
  tplp_txin_s  tx_in  [2];
  tplp_tx_s    tx_out [2];
  tplp_rpt_s   rpt    [2];
  logic [1:0]  link_status, pol_status, m_good, m_neg;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, seed;
  int          mismatches, num_checks, cyc, n;

  tplp_top #(.NPORTS(2), .FAIL_CYC(FAIL), .TXI_CYC(TXI)) i_dut (
    .sys_clk(sys_clk), .reset(reset), .rx(rx), .tx_in(tx_in),
    .tx_out(tx_out), .rpt(rpt), .link_status(link_status),
    .pol_status(pol_status), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq));
  tplp_remote i_rem0 (.sys_clk(sys_clk), .tx(tx_out[0]), .rx(rx[0]));
  tplp_remote i_rem1 (.sys_clk(sys_clk), .tx(tx_out[1]), .rx(rx[1]));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic state();
    cmp("link", m_good, link_status);
    cmp("pol", m_neg, pol_status);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // slave answer read at the edge, before that edge's updates settle
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    #1;
  endtask
  always @(posedge sys_clk) begin
    d_smp = rx[0].data;
    v_smp = rx[0].crs;
    if (++cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
    #1;
    if (v_smp) begin
      cmp("rpt_vld", exp_vld, rpt[0].vld);
      if (exp_vld) cmp("rpt_data", d_smp ^ exp_inv, rpt[0].data);
    end
  end

  initial begin
    reset = 1'b1;
    seed = 32'd99762;
    {exp_vld, exp_inv, m_good, m_neg} = '0;
    {mismatches, num_checks, cyc} = '0;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    tx_in = '{default: '0};
    tick(6);
    state();
    reset <= 1'b0;
    bus(0, 5'h00, 0);
    cmp("ctrl", 3, q);
    bus(0, 5'h14, 0);
    cmp("unmapped", 0, q);
    bus(1, 5'h10, 1);
    i_rem0.pulses(5, 0);
    state();
    i_rem0.pulses(1, 0);
    m_good = 2'b01;
    state();
    cmp("irq", 1, irq);
    bus(0, 5'h0c, 0);
    cmp("istat", 1, q);
    cmp("irq", 0, irq);
    $display("test pulse run done");
    i_rem0.pulses(1, 0);
    n = i_rem0.lp_cnt;
    tick(FAIL - 30);
    state();
    cmp("idle_lp", 1, (i_rem0.lp_cnt - n) inside {[3:4]});
    tick(40);
    m_good = 2'b00;
    state();
    tx_in[0].req <= 1'b1;
    n = i_rem0.lp_cnt;
    tick(TXI * 2);
    cmp("tx_en", 0, tx_out[0].en);
    cmp("fail_lp", n, i_rem0.lp_cnt);
    $display("test fail timing done");
    i_rem0.packet(16, 0, rnd());
    m_good = 2'b01;
    state();
    cmp("tx_en", 1, tx_out[0].en);
    exp_vld = 1'b1;
    i_rem0.packet(24, 0, rnd());
    tx_in[0].req <= 1'b0;
    $display("test packets done");
    tick(FAIL + 20);
    m_good = 2'b00;
    state();
    i_rem0.pulses(3, 1);
    m_neg = 2'b01;
    state();
    i_rem0.pulses(3, 0);
    m_good = 2'b01;
    state();
    exp_inv = 1'b1;
    i_rem0.packet(20, 0, rnd());
    bus(1, 5'h00, 1);
    tick(2);
    state();
    $display("test polarity done");
    reset <= 1'b1;
    tick(1);
    cmp("pol_rst", 0, pol_status);
    tick(5);
    {m_good, m_neg} = '0;
    state();
    reset <= 1'b0;
    bus(0, 5'h00, 0);
    cmp("ctrl", 3, q);
    bus(1, 5'h00, 2);
    tick(2);
    m_good = 2'b11;
    state();
    tick(FAIL + 20);
    state();
    cmp("irq_masked", 0, irq);
    bus(0, 5'h0c, 0);
    cmp("istat", 3, q);
    $display("test link test disable done");
    wrap_up();
  end
endmodule
